// *** design/rsfo_map.svh ***
`ifndef RSFO_MAP_SVH
`define RSFO_MAP_SVH
// option register offsets
`define RSFO_ADDR_SEQ     8'h79
`define RSFO_ADDR_SS      8'h7A
`define RSFO_ADDR_MISC    8'h7B
// reset values
`define RSFO_SEQ_RST      8'h00
`define RSFO_SS_RST       8'h00
`define RSFO_MISC_RST     8'h00
// writable bits, reserved bits stay zero
`define RSFO_SEQ_WMASK    8'hBF
`define RSFO_SS_WMASK     8'h07
`define RSFO_MISC_WMASK   8'hFF
// field positions
`define RSFO_ORDER_BIT    7
`define RSFO_TOFF_MSB     5
`define RSFO_TOFF_LSB     3
`define RSFO_TON_MSB      2
`define RSFO_TON_LSB      0
`define RSFO_SS_MSB       2
`define RSFO_SS_LSB       0
`define RSFO_FRSP_MSB     7
`define RSFO_FRSP_LSB     6
`define RSFO_UVF_MSB      5
`define RSFO_UVF_LSB      4
`define RSFO_PD_MSB       3
`define RSFO_PD_LSB       1
`define RSFO_PHASE_BIT    0
// fault response codes and retry limits
`define RSFO_FRSP_FOREVER 2'h0
`define RSFO_FRSP_FIVE    2'h1
`define RSFO_FRSP_TEN     2'h2
`define RSFO_FRSP_LATCH   2'h3
`define RSFO_RETRY_LIM1   4'h5
`define RSFO_RETRY_LIM2   4'hA
// spread spectrum codes and fixed dwells
`define RSFO_SS_OFF       3'h0
`define RSFO_SS_TWO_SLOPE 3'h1
`define RSFO_SS_RND_1_8   3'h2
`define RSFO_SS_RND_4_32  3'h3
`define RSFO_SS_TRIANGLE  3'h4
`define RSFO_SS_FIX4      3'h5
`define RSFO_SS_FIX8      3'h6
`define RSFO_SS_FIX24     3'h7
`define RSFO_DWELL_FIX4   6'h04
`define RSFO_DWELL_FIX8   6'h08
`define RSFO_DWELL_FIX24  6'h18
// clock rate and times in their own units
`define RSFO_CLK_MHZ      125
`define RSFO_DLY_STEP_US  500
`define RSFO_HICCUP_MS    200
`define RSFO_PD_MS        200
`define RSFO_UV_FIX_NS    2000
`define RSFO_UV_F1_US     10
`define RSFO_UV_F2_US     25
`define RSFO_UV_F3_US     45
`define RSFO_SW_FREQ_KHZ  2200
`define RSFO_TRI_MOD_HZ   8850
`define RSFO_TWO_MOD_HZ   9130
// derived cycle counts
`define RSFO_UV_FIX_CYC   (`RSFO_UV_FIX_NS * `RSFO_CLK_MHZ / 1000)
`define RSFO_UV_F1_CYC    (`RSFO_UV_F1_US * `RSFO_CLK_MHZ)
`define RSFO_UV_F2_CYC    (`RSFO_UV_F2_US * `RSFO_CLK_MHZ)
`define RSFO_SW_CYC       (`RSFO_CLK_MHZ * 1000 / `RSFO_SW_FREQ_KHZ)
`define RSFO_TRI_STEP_CYC (`RSFO_CLK_MHZ * 1000000 / (`RSFO_TRI_MOD_HZ * 32))
`define RSFO_TWO_UP_CYC   (`RSFO_CLK_MHZ * 1000000 / (`RSFO_TWO_MOD_HZ * 64))
`define RSFO_TWO_DN_CYC   (`RSFO_CLK_MHZ * 3000000 / (`RSFO_TWO_MOD_HZ * 64))
`endif

// *** design/rsfo_pkg.sv ***
package rsfo_pkg;
   // sequencer states
   typedef enum logic [2:0] {
      ST_OFF,
      ST_UP,
      ST_ON,
      ST_DOWN,
      ST_HICCUP,
      ST_LATCHED
   } rsfo_state_e;
   // option register access request
   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } rsfo_reg_req_s;
   // long timer word
   typedef logic [24:0] rsfo_timer_t;
endpackage

// *** design/rsfo_top.sv ***
`timescale 1ns/10ps
`include "rsfo_map.svh"
// What this block does
// (RQ1) order 0: start A, B, linear; stop linear, B, A
// (RQ2) order 1: start linear, A, B; stop B, A, linear
// (RQ3) bits 5:3 pick stop spacing 0, 0.5, 1 ... 32 ms
// (RQ4) bits 2:0 pick start spacing with the same table
// (RQ5) spread code 0 off, 1 two-slope 9.13 kHz, 4 triangle 8.85 kHz
// (RQ6) code 2: random frequency held 1 to 8 switching cycles
// (RQ7) code 3: random frequency held 4 to 32 cycles, steps of 4
// (RQ8) codes 5, 6, 7: random frequency held 4, 8, 24 cycles
// (RQ9) hiccup shuts the rails 200 ms then restarts
// (RQ10) response 0 retries without limit
// (RQ11) response 1 or 2 retries 5 or 10 times then latches off
// (RQ12) response 3 latches off at once, no restart
// (RQ13) clearing the latch bits restarts latched-off outputs
// (RQ14) undervoltage filter adds 0, 10, 25 or 45 us, all four outputs
// (RQ15) fixed 2 us undervoltage detection delay always applies
// (RQ16) clear disable bit gives 200 ms pull-down at rail shutoff
// (RQ17) phase bit clear runs rail B 180 degrees from high-voltage buck
// (RQ18) reserved option bits read zero and do nothing
module rsfo_top import rsfo_pkg::*; #(
   parameter int HALF_MS_CYC = `RSFO_DLY_STEP_US * `RSFO_CLK_MHZ,
   parameter int HICCUP_CYC  = `RSFO_HICCUP_MS * 1000 * `RSFO_CLK_MHZ,
   parameter int PD_CYC      = `RSFO_PD_MS * 1000 * `RSFO_CLK_MHZ,
   parameter int UV_F3_CYC   = `RSFO_UV_F3_US * `RSFO_CLK_MHZ
) (
   // clock and reset
   input  wire logic          clk,
   input  wire logic          nrst,
   // option register port
   input  wire rsfo_reg_req_s reg_req,
   output logic [7:0]         reg_rdata,
   // pins from the enable front end and monitors
   input  wire logic          seq_enable,
   input  wire logic [3:0]    uv_raw,
   input  wire logic [3:0]    fault_raw,
   // latch release from the fault-clear register
   input  wire logic          latch_clear,
   // rail controls, bit 0 rail A, bit 1 rail B, bit 2 linear
   output logic [2:0]         rail_en,
   output logic [2:0]         rail_pulldown,
   output logic               lv_b_phase_180,
   // spread spectrum
   output logic               ss_active,
   output logic [3:0]         ss_freq_sel,
   // status
   output logic [3:0]         uv_detect,
   output logic               latched_off,
   output logic [3:0]         retry_count
);

   logic        rst_s1;
   logic        rst_n;
   logic [8:0]  in_s1;
   logic [8:0]  in_s2;
   logic [7:0]  seq_opt;
   logic [7:0]  ss_opt;
   logic [7:0]  misc_opt;
   rsfo_state_e state;
   rsfo_state_e next_state;
   logic [1:0]  step;
   logic [1:0]  next_step;
   rsfo_timer_t timer;
   rsfo_timer_t next_timer;
   logic [2:0]  next_rail;
   logic [3:0]  next_retries;
   logic [5:0]  sw_cnt;
   logic [7:0]  lfsr;
   logic [5:0]  dwell;
   logic [9:0]  mod_cnt;
   logic [3:0]  level;
   logic        ramp_up;

   // reset release through two flops
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         rst_s1 <= 1'b0;
         rst_n  <= 1'b0;
      end else begin
         rst_s1 <= 1'b1;
         rst_n  <= rst_s1;
      end
   end

   // pin synchronisers
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         in_s1 <= 9'h000;
         in_s2 <= 9'h000;
      end else begin
         in_s1 <= {seq_enable, uv_raw, fault_raw};
         in_s2 <= in_s1;
      end
   end

   wire       en_s   = in_s2[8];
   wire [3:0] uv_s   = in_s2[7:4];
   wire [3:0] flt_s  = in_s2[3:0];

   // register decode
   wire sel_seq  = reg_req.addr == `RSFO_ADDR_SEQ;
   wire sel_ss   = reg_req.addr == `RSFO_ADDR_SS;
   wire sel_misc = reg_req.addr == `RSFO_ADDR_MISC;
   wire [7:0] rd_mux = sel_seq  ? seq_opt :
                       sel_ss   ? ss_opt :
                       sel_misc ? misc_opt : 8'h00;

   // option registers, reserved bits masked off
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         seq_opt   <= `RSFO_SEQ_RST;
         ss_opt    <= `RSFO_SS_RST;
         misc_opt  <= `RSFO_MISC_RST;
         reg_rdata <= 8'h00;
      end else begin
         if (reg_req.wr && sel_seq) seq_opt <= reg_req.wdata & `RSFO_SEQ_WMASK;    // RQ18
         if (reg_req.wr && sel_ss) ss_opt <= reg_req.wdata & `RSFO_SS_WMASK;      // RQ18
         if (reg_req.wr && sel_misc) misc_opt <= reg_req.wdata & `RSFO_MISC_WMASK;
         if (reg_req.rd) reg_rdata <= rd_mux;
      end
   end

   // option fields
   wire       order1   = seq_opt[`RSFO_ORDER_BIT];
   wire [2:0] toff_cd  = seq_opt[`RSFO_TOFF_MSB:`RSFO_TOFF_LSB];
   wire [2:0] ton_cd   = seq_opt[`RSFO_TON_MSB:`RSFO_TON_LSB];
   wire [2:0] ss_cd    = ss_opt[`RSFO_SS_MSB:`RSFO_SS_LSB];
   wire [1:0] frsp_cd  = misc_opt[`RSFO_FRSP_MSB:`RSFO_FRSP_LSB];
   wire [1:0] uvf_cd   = misc_opt[`RSFO_UVF_MSB:`RSFO_UVF_LSB];
   wire [2:0] pd_dis   = misc_opt[`RSFO_PD_MSB:`RSFO_PD_LSB];

   assign lv_b_phase_180 = ~misc_opt[`RSFO_PHASE_BIT];                          // RQ17
   assign latched_off    = state == ST_LATCHED;

   // spacing between sequence steps: 0, then 0.5 ms doubling
   function automatic rsfo_timer_t step_delay(input logic [2:0] code);
      step_delay = (code == 3'h0) ? 25'h000_0000 : 25'(HALF_MS_CYC) << (code - 3'h1);
   endfunction

   // one-hot rail for a step; stopping walks the start order backwards
   function automatic logic [2:0] rail_at(input logic ord, input logic up,
                                          input logic [1:0] stp);
      logic [1:0] idx;
      idx = up ? stp : 2'h2 - stp;
      if (ord)
         rail_at = (idx == 2'h0) ? 3'h4 : (idx == 2'h1) ? 3'h1 : 3'h2;          // RQ2
      else
         rail_at = (idx == 2'h0) ? 3'h1 : (idx == 2'h1) ? 3'h2 : 3'h4;          // RQ1
   endfunction

   // undervoltage recognition threshold
   wire [12:0] uv_thr = (uvf_cd == 2'h0) ? 13'(`RSFO_UV_FIX_CYC) :              // RQ15
                        (uvf_cd == 2'h1) ? 13'(`RSFO_UV_FIX_CYC + `RSFO_UV_F1_CYC) :
                        (uvf_cd == 2'h2) ? 13'(`RSFO_UV_FIX_CYC + `RSFO_UV_F2_CYC) :
                                           13'(`RSFO_UV_FIX_CYC + UV_F3_CYC);   // RQ14

   // per-output undervoltage filter, bit 3 high-voltage buck
   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++) begin : g_uv
         logic [12:0] cnt;
         always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
               cnt           <= 13'h0000;
               uv_detect[gi] <= 1'b0;
            end else if (!uv_s[gi]) begin
               cnt           <= 13'h0000;
               uv_detect[gi] <= 1'b0;
            end else if (cnt >= uv_thr) begin
               uv_detect[gi] <= 1'b1;                                           // RQ14
            end else begin
               cnt <= cnt + 13'h0001;
            end
         end
      end
   endgenerate

   // faults only count on outputs that are running
   wire       hv_mon    = (state == ST_UP) || (state == ST_ON);
   wire [3:0] armed     = {hv_mon, rail_en & {3{hv_mon}}};
   wire       fault_hit = |((uv_detect | flt_s) & armed);
   wire [3:0] retry_lim = (frsp_cd == `RSFO_FRSP_FIVE) ? `RSFO_RETRY_LIM1 : `RSFO_RETRY_LIM2;
   wire       go_latch  = (frsp_cd == `RSFO_FRSP_LATCH) ||                        // RQ12
                          ((frsp_cd != `RSFO_FRSP_FOREVER) && (retry_count >= retry_lim));

   // sequencer next state
   always_comb begin
      next_state   = state;
      next_step    = step;
      next_timer   = (timer == 25'h000_0000) ? timer : timer - 25'h000_0001;
      next_rail    = rail_en;
      next_retries = retry_count;
      if (fault_hit) begin
         next_rail = 3'h0;
         if (go_latch) begin
            next_state = ST_LATCHED;                                            // RQ11
         end else begin
            next_state = ST_HICCUP;                                             // RQ9
            next_timer = 25'(HICCUP_CYC);
            if (retry_count != 4'hF) next_retries = retry_count + 4'h1;          // RQ10
         end
      end else begin
         unique case (state)
            ST_OFF: begin
               if (en_s) begin
                  next_state   = ST_UP;
                  next_step    = 2'h0;
                  next_timer   = 25'h000_0000;
                  next_retries = 4'h0;
               end
            end
            ST_UP: begin
               if (!en_s) begin
                  next_state = ST_DOWN;
                  next_step  = 2'h0;
                  next_timer = 25'h000_0000;
               end else if (timer == 25'h000_0000) begin
                  next_rail = rail_en | rail_at(order1, 1'b1, step);
                  if (step == 2'h2) begin
                     next_state = ST_ON;
                  end else begin
                     next_step  = step + 2'h1;
                     next_timer = step_delay(ton_cd);                           // RQ4
                  end
               end
            end
            ST_ON: begin
               if (!en_s) begin
                  next_state = ST_DOWN;
                  next_step  = 2'h0;
                  next_timer = 25'h000_0000;
               end
            end
            ST_DOWN: begin
               if (timer == 25'h000_0000) begin
                  next_rail = rail_en & ~rail_at(order1, 1'b0, step);
                  if (step == 2'h2) begin
                     next_state = ST_OFF;
                  end else begin
                     next_step  = step + 2'h1;
                     next_timer = step_delay(toff_cd);                          // RQ3
                  end
               end
            end
            ST_HICCUP: begin
               if (timer == 25'h000_0000) begin
                  next_state = en_s ? ST_UP : ST_OFF;                           // RQ9
                  next_step  = 2'h0;
               end
            end
            ST_LATCHED: begin
               if (latch_clear) begin
                  next_state   = en_s ? ST_UP : ST_OFF;                         // RQ13
                  next_step    = 2'h0;
                  next_timer   = 25'h000_0000;
                  next_retries = 4'h0;
               end
            end
         endcase
      end
   end

   // sequencer registers
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state       <= ST_OFF;
         step        <= 2'h0;
         timer       <= 25'h000_0000;
         rail_en     <= 3'h0;
         retry_count <= 4'h0;
      end else begin
         state       <= next_state;
         step        <= next_step;
         timer       <= next_timer;
         rail_en     <= next_rail;
         retry_count <= next_retries;
      end
   end

   // pull-down timer per low-voltage rail
   generate
      for (gi = 0; gi < 3; gi++) begin : g_pd
         rsfo_timer_t pd_cnt;
         wire         turn_off = rail_en[gi] && !next_rail[gi];
         wire         turn_on  = !rail_en[gi] && next_rail[gi];
         always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
               pd_cnt            <= 25'h000_0000;
               rail_pulldown[gi] <= 1'b0;
            end else if (turn_off && !pd_dis[gi]) begin
               pd_cnt            <= 25'(PD_CYC);                                // RQ16
               rail_pulldown[gi] <= 1'b1;
            end else if (turn_on || pd_cnt <= 25'h000_0001) begin
               pd_cnt            <= 25'h000_0000;
               rail_pulldown[gi] <= 1'b0;
            end else begin
               pd_cnt <= pd_cnt - 25'h000_0001;
            end
         end
      end
   endgenerate

   // spread spectrum mode decode
   wire       sw_tick   = sw_cnt == 6'(`RSFO_SW_CYC - 1);
   wire       ramp_mode = (ss_cd == `RSFO_SS_TWO_SLOPE) || (ss_cd == `RSFO_SS_TRIANGLE);
   wire       rand_mode = !ramp_mode && (ss_cd != `RSFO_SS_OFF);
   wire [9:0] mod_int   = (ss_cd == `RSFO_SS_TRIANGLE) ? 10'(`RSFO_TRI_STEP_CYC) :
                          ramp_up ? 10'(`RSFO_TWO_UP_CYC) : 10'(`RSFO_TWO_DN_CYC);
   wire       mod_tick  = mod_cnt >= mod_int - 10'h001;
   wire [5:0] rnd_low   = {3'h0, lfsr[2:0]} + 6'h01;
   wire [5:0] new_dwell = (ss_cd == `RSFO_SS_RND_1_8)  ? rnd_low :               // RQ6
                          (ss_cd == `RSFO_SS_RND_4_32) ? {rnd_low[3:0], 2'h0} :  // RQ7
                          (ss_cd == `RSFO_SS_FIX4)     ? `RSFO_DWELL_FIX4 :      // RQ8
                          (ss_cd == `RSFO_SS_FIX8)     ? `RSFO_DWELL_FIX8 :
                                                         `RSFO_DWELL_FIX24;
   wire [7:0] next_lfsr = {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};

   assign ss_active = ss_cd != `RSFO_SS_OFF;                                     // RQ5

   // switching cycle tick and random dwell
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sw_cnt <= 6'h00;
         lfsr   <= 8'h01;
         dwell  <= 6'h00;
      end else begin
         sw_cnt <= sw_tick ? 6'h00 : sw_cnt + 6'h01;
         if (sw_tick) begin
            lfsr  <= next_lfsr;
            dwell <= (dwell <= 6'h01) ? new_dwell : dwell - 6'h01;
         end
      end
   end

   // modulation ramp and frequency select
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         mod_cnt     <= 10'h000;
         level       <= 4'h0;
         ramp_up     <= 1'b1;
         ss_freq_sel <= 4'h0;
      end else begin
         mod_cnt <= (mod_tick || !ramp_mode) ? 10'h000 : mod_cnt + 10'h001;
         if (ramp_mode && mod_tick) begin
            level   <= ramp_up ? level + 4'h1 : level - 4'h1;
            ramp_up <= ramp_up ? (level != 4'hE) : (level == 4'h1);
         end
         if (!ss_active)
            ss_freq_sel <= 4'h0;                                                 // RQ5
         else if (ramp_mode)
            ss_freq_sel <= level;                                                // RQ5
         else if (rand_mode && sw_tick && dwell <= 6'h01)
            ss_freq_sel <= lfsr[7:4];                                            // RQ6
      end
   end

endmodule

// *** testbench/rsfo_chk.sv ***
`timescale 1ns/10ps
module rsfo_chk import rsfo_pkg::*; #(
   parameter int HALF_MS_CYC = 4
) (
   // clock and reset
   input wire logic          clk,
   input wire logic          nrst,
   // inputs seen
   input wire rsfo_reg_req_s reg_req,
   input wire logic          seq_enable,
   input wire logic [3:0]    uv_raw,
   input wire logic          latch_clear,
   // outputs watched
   input wire logic [2:0]    rail_en,
   input wire logic [2:0]    rail_pulldown,
   input wire logic          lv_b_phase_180,
   input wire logic          ss_active,
   input wire logic [3:0]    uv_detect,
   input wire logic          latched_off,
   input wire logic [3:0]    retry_count
);
   logic [7:0]  seq_q;
   logic [7:0]  ss_q;
   logic [7:0]  misc_q;
   logic [2:0]  prev_en;
   logic [15:0] gap;
   logic [9:0]  uv_cnt;

   // write decode per option register
   wire wr_seq  = reg_req.wr && reg_req.addr == 8'h79;
   wire wr_ss   = reg_req.wr && reg_req.addr == 8'h7A;
   wire wr_misc = reg_req.wr && reg_req.addr == 8'h7B;

   // step spacing in cycles for a delay code
   function automatic int dly(input logic [2:0] c);
      return (c == 3'h0) ? 0 : HALF_MS_CYC << (c - 3'h1);
   endfunction

   // option shadows, cycles since last rail change, undervoltage run
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         seq_q   <= 8'h00;
         ss_q    <= 8'h00;
         misc_q  <= 8'h00;
         prev_en <= 3'h0;
         gap     <= 16'h0000;
         uv_cnt  <= 10'h000;
      end else begin
         if (wr_seq)
            seq_q <= reg_req.wdata;
         if (wr_ss)
            ss_q <= reg_req.wdata;
         if (wr_misc)
            misc_q <= reg_req.wdata;
         prev_en <= rail_en;
         gap     <= (rail_en != prev_en) ? 16'h0001 : gap + 16'h0001;
         uv_cnt  <= uv_raw[0] ? uv_cnt + {9'h000, ~&uv_cnt} : 10'h000;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);

   // rail transitions
   sequence s_first_up;
      $past(rail_en) == 3'h0 && rail_en != 3'h0;
   endsequence
   sequence s_step_up;
      $past(rail_en) != 3'h0 && (rail_en & ~$past(rail_en)) != 3'h0;
   endsequence
   sequence s_step_dn;
      !seq_enable && $past(rail_en) != 3'h7 && rail_en != $past(rail_en)
         && (rail_en & ~$past(rail_en)) == 3'h0;
   endsequence

   start_order_a: assert property (s_first_up |-> rail_en == (seq_q[7] ? 3'h4 : 3'h1))
      else $error("wrong first rail at start");
   stop_order_a: assert property ($past(rail_en) == 3'h7 && $countones(rail_en) == 2
      |-> rail_en == (seq_q[7] ? 3'h5 : 3'h3))
      else $error("wrong first rail at stop");
   on_spacing_a: assert property (s_step_up |-> gap == dly(seq_q[2:0]) + 1)
      else $error("start spacing wrong");
   off_spacing_a: assert property (s_step_dn |-> gap == dly(seq_q[5:3]) + 1)
      else $error("stop spacing wrong");
   ss_enable_a: assert property (ss_active == (ss_q[2:0] != 3'h0))
      else $error("spread enable wrong");
   phase_sel_a: assert property (lv_b_phase_180 == !misc_q[0])
      else $error("phase select wrong");
   pulldown_on_a: assert property (($past(rail_en) & ~rail_en) != 3'h0 |->
      (rail_pulldown & $past(rail_en) & ~rail_en) == ($past(rail_en) & ~rail_en & ~misc_q[3:1]))
      else $error("pull-down at shutoff wrong");
   latch_rails_a: assert property (latched_off |-> rail_en == 3'h0)
      else $error("rail on while latched");
   latch_release_a: assert property (latched_off && latch_clear
      |=> !latched_off && retry_count == 4'h0)
      else $error("latch not released");
   retry_limit_a: assert property ($rose(latched_off) |->
      (misc_q[7:6] != 2'h1 || retry_count == 4'h5) && (misc_q[7:6] != 2'h2 || retry_count == 4'hA))
      else $error("latched at wrong retry count");
   no_latch_a: assert property (misc_q[7:6] == 2'h0 |-> !$rose(latched_off))
      else $error("latched with endless retry");
   uv_delay_a: assert property ($rose(uv_detect[0]) |-> uv_cnt >= 10'h0FA)
      else $error("undervoltage seen too early");
endmodule

// *** testbench/rsfo_top_tb.sv ***
`timescale 1ns/10ps
module rsfo_top_tb import rsfo_pkg::*;;
   localparam int HALF = 4;
   localparam int HIC  = 50;
   localparam int PD   = 30;
   localparam int UVF3 = 100;

   logic          clk = 1'b0;
   logic          nrst = 1'b0;
   rsfo_reg_req_s reg_req = '0;
   logic [7:0]    reg_rdata;
   logic          seq_enable = 1'b0;
   logic [3:0]    uv_raw = 4'h0;
   logic [3:0]    fault_raw = 4'h0;
   logic          latch_clear = 1'b0;
   logic [2:0]    rail_en;
   logic [2:0]    rail_pulldown;
   logic          lv_b_phase_180;
   logic          ss_active;
   logic          latched_off;
   logic [3:0]    ss_freq_sel;
   logic [3:0]    uv_detect;
   logic [3:0]    retry_count;
   int            errors = 0;
   int            total_checks = 0;
   int            n;
   int            chg;
   logic [7:0]    msk [4] = '{8'hBF, 8'h07, 8'hFF, 8'h00};
   logic [3:0]    lim [4] = '{4'h0, 4'h5, 4'hA, 4'h0};
   int            thr [4] = '{250, 1500, 3375, 250 + UVF3};
   int            gap_min [8] = '{1, 213, 56, 224, 441, 224, 448, 1344};

`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin errors++; \
   $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end

   // clock
   always #4 clk = ~clk;

   rsfo_top #(.HALF_MS_CYC(HALF), .HICCUP_CYC(HIC), .PD_CYC(PD), .UV_F3_CYC(UVF3))
   rsfo_top_inst (
      .clk(clk), .nrst(nrst), .reg_req(reg_req), .reg_rdata(reg_rdata),
      .seq_enable(seq_enable), .uv_raw(uv_raw), .fault_raw(fault_raw),
      .latch_clear(latch_clear), .rail_en(rail_en), .rail_pulldown(rail_pulldown),
      .lv_b_phase_180(lv_b_phase_180), .ss_active(ss_active), .ss_freq_sel(ss_freq_sel),
      .uv_detect(uv_detect), .latched_off(latched_off), .retry_count(retry_count));

   // bus and wait helpers
   task automatic tick();
      @(posedge clk);
      #1;
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      tick();
      reg_req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      tick();
      reg_req.wr = 1'b0;
   endtask
   task automatic rchk(input logic [7:0] a, input logic [7:0] e);
      tick();
      reg_req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
      tick();
      reg_req.rd = 1'b0;
      `CHK(reg_rdata, e)
   endtask
   task automatic guard();
      if (n >= 5000) begin
         errors++;
         report_and_stop();
      end
   endtask
   task automatic wait_en(input logic [2:0] e);
      n = 0;
      while (rail_en !== e && n < 5000) begin
         tick();
         n++;
      end
      guard();
   endtask
   task automatic step(input logic [2:0] e, input int c);
      logic [2:0] p;
      p = rail_en;
      n = 0;
      while (rail_en === p && n < 5000) begin
         tick();
         n++;
      end
      guard();
      `CHK(rail_en, e)
      if (c > 0)
         `CHK(n, c)
   endtask
   task automatic report_and_stop();
      $display("checks %0d errors %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   // main sequence
   initial begin
      repeat (3) @(posedge clk);
      #1;
      nrst = 1'b1;
      repeat (3) tick();
      for (int i = 0; i < 3; i++)
         rchk(8'(8'h79 + i), 8'h00);
      `CHK(lv_b_phase_180, 1'b1)
      for (int i = 0; i < 4; i++) begin
         wr(8'(8'h79 + i), 8'hFF);
         rchk(8'(8'h79 + i), msk[i]);
      end
      `CHK(lv_b_phase_180, 1'b0)
      // only nonzero spread codes set ss_active; nonzero codes move, but no faster than their shortest hold
      for (int c = 0; c < 8; c++) begin
         wr(8'h7A, 8'(c));
         `CHK(ss_active, c != 0)
         if (c > 0) begin
            chg = 0;
            for (int t = 0; t < 2688; t++) begin
               n = ss_freq_sel;
               tick();
               chg += (ss_freq_sel !== 4'(n));
            end
            `CHK(chg > 0 && chg <= 2688 / gap_min[c] + 1, 1'b1)
         end
      end
      wr(8'h7A, 8'h00);
      // order 0 with slow steps
      wr(8'h7B, 8'h00);
      wr(8'h79, 8'h11);
      seq_enable = 1'b1;
      step(3'h1, 0);
      step(3'h3, HALF + 1);
      step(3'h7, HALF + 1);
      seq_enable = 1'b0;
      step(3'h3, 0);
      `CHK(rail_pulldown, 3'h4)
      step(3'h1, 2 * HALF + 1);
      step(3'h0, 2 * HALF + 1);
      repeat (PD - 4 * HALF) tick();
      `CHK(rail_pulldown, 3'h3)
      // order 1, linear pull-down disabled
      repeat (30) tick();
      wr(8'h79, 8'h80);
      wr(8'h7B, 8'h08);
      seq_enable = 1'b1;
      step(3'h4, 0);
      step(3'h5, 1);
      step(3'h7, 1);
      seq_enable = 1'b0;
      step(3'h5, 0);
      step(3'h4, 1);
      step(3'h0, 1);
      `CHK(rail_pulldown, 3'h3)
      // endless hiccup
      wr(8'h79, 8'h01);
      seq_enable = 1'b1;
      wait_en(3'h7);
      fault_raw = 4'h1;
      step(3'h0, 0);
      step(3'h1, 0);
      `CHK(n >= HIC && n < HIC + 8, 1'b1)
      repeat (7) begin
         wait_en(3'h0);
         step(3'h1, 0);
      end
      `CHK(latched_off, 1'b0)
      fault_raw = 4'h0;
      wait_en(3'h7);
      // bounded retries and latch-off
      for (int k = 1; k < 4; k++) begin
         seq_enable = 1'b0;
         wait_en(3'h0);
         wr(8'h7B, {2'(k), 6'h08});
         seq_enable = 1'b1;
         wait_en(3'h7);
         fault_raw = 4'h1;
         n = 0;
         while (latched_off !== 1'b1 && n < 5000) begin
            tick();
            n++;
         end
         guard();
         `CHK(retry_count, lim[k])
         repeat (HIC + 20) tick();
         `CHK(rail_en, 3'h0)
         fault_raw = 4'h0;
         latch_clear = 1'b1;
         tick();
         latch_clear = 1'b0;
         wait_en(3'h7);
         `CHK(retry_count, 4'h0)
      end
      // undervoltage filter per code, one output each
      seq_enable = 1'b0;
      wait_en(3'h0);
      for (int k = 0; k < 4; k++) begin
         wr(8'h7B, {2'h0, 2'(k), 4'h8});
         uv_raw = 4'h1 << k;
         n = 0;
         while (uv_detect[k] !== 1'b1 && n < 5000) begin
            tick();
            n++;
         end
         guard();
         `CHK(n >= thr[k] && n <= thr[k] + 6, 1'b1)
         `CHK(uv_detect, 4'h1 << k)
         uv_raw = 4'h0;
         repeat (8) tick();
      end
      report_and_stop();
   end
endmodule

bind rsfo_top rsfo_chk #(.HALF_MS_CYC(HALF_MS_CYC)) rsfo_chk_inst (
   .clk(clk), .nrst(nrst), .reg_req(reg_req), .seq_enable(seq_enable),
   .uv_raw(uv_raw), .latch_clear(latch_clear), .rail_en(rail_en),
   .rail_pulldown(rail_pulldown), .lv_b_phase_180(lv_b_phase_180),
   .ss_active(ss_active), .uv_detect(uv_detect), .latched_off(latched_off),
   .retry_count(retry_count));
